// file: inc/fcsu_pkg.sv
// fcsu_pkg: constants and carrier types of the flash command/status unit.
// assumes a byte-wide register port and a single 250 MHz system clock.
package fcsu_pkg;
  // register port geometry
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  // register offsets
  localparam logic [ADDR_W-1:0] OFS_STATUS = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_COMMAND = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_DIVIDER = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 3'h4;
  // status register bit positions
  localparam int ST_BUF_EMPTY = 7;
  localparam int ST_COMPLETE = 6;
  localparam int ST_PROT_VIOL = 5;
  localparam int ST_ACC_ERR = 4;
  localparam int ST_BLANK = 2;
  // interrupt status bit positions
  localparam int IRQ_W = 4;
  localparam int IQ_DONE = 0;
  localparam int IQ_PROT = 1;
  localparam int IQ_ACCERR = 2;
  localparam int IQ_BLANK = 3;
  // command codes
  localparam logic [DATA_W-1:0] BLANK_CHECK_CMD = 8'h05;
  localparam logic [DATA_W-1:0] BYTE_PROGRAM_CMD = 8'h20;
  localparam logic [DATA_W-1:0] BURST_PROGRAM_CMD = 8'h25;
  localparam logic [DATA_W-1:0] PAGE_ERASE_CMD = 8'h40;
  localparam logic [DATA_W-1:0] MASS_ERASE_CMD = 8'h41;
  localparam int PAGE_BYTES = 512;
  // reset values
  localparam logic [DATA_W-1:0] COMMAND_RST = 8'h00;
  localparam logic [DATA_W-1:0] DIVIDER_RST = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;
  localparam logic [1:0] SEC_SECURED = 2'h0;
  localparam logic [1:0] SEC_UNSECURED = 2'h2;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  // software command sequence
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_DATA,
    SEQ_CMD
  } fcsu_seq_t;
  // register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } fcsu_bus_req_t;
  // order to the array engine
  typedef struct packed {
    logic start;
    logic [DATA_W-1:0] code;
  } fcsu_exec_t;
endpackage

// file: src/fcsu_top.sv
// fcsu_top: command launch, sequencing and status flags of a flash unit.
// assumes the array engine, stop indication and array-write strobe all run
// on sys_clk_in; the engine reports the end of each command by done pulse.
//
// Behaviour
// - status bits 3, 1, 0 read zero; writes to them ignored.
// - writing one to buffer-empty bit 7 launches; sets again on burst transfer.
// - only burst program buffers; empty flag 0 when full, 1 when free.
// - complete bit 6 sets when idle and empty; clears on launch.
// - protected program or erase sets bit 5, command dropped; one clears.
// - broken command sequence sets access error bit 4, command dropped.
// - program or erase before divider written raises access error.
// - stop entry while command executes raises access error.
// - access error clears only by writing one; zero leaves it.
// - blank check end sets blank bit 2 when whole array erased.
// - blank bit clears on new valid launch; direct writes ignored.
// - command register accepts 0x05, 0x20, 0x25 and two erase codes.
// - 0x40 erases one 512-byte page, 0x41 erases whole array.
// - any other command code is illegal and raises access error.
// - successful blank check sets security field to unsecured 1:0.
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module fcsu_top (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // register port
  input wire fcsu_pkg::fcsu_bus_req_t bus_in,
  output fcsu_pkg::fcsu_bus_req_t unused_out,
  output logic [fcsu_pkg::DATA_W-1:0] rdata_out,
  // software side events and system state
  input wire logic array_wr_in,
  input wire logic target_protected_in,
  input wire logic stop_mode_in,
  // array engine
  output fcsu_pkg::fcsu_exec_t exec_out,
  input wire logic exec_done_in,
  input wire logic blank_ok_in,
  // security and interrupt
  output logic [1:0] security_state_field_out,
  output logic irq_out
);
  import fcsu_pkg::*;

  // decode of the five recognised codes, shared by launch and checks
  function automatic logic is_legal(input logic [DATA_W-1:0] c);
    return c == BLANK_CHECK_CMD || c == BYTE_PROGRAM_CMD ||
           c == BURST_PROGRAM_CMD || c == PAGE_ERASE_CMD ||
           c == MASS_ERASE_CMD;
  endfunction

  function automatic logic is_prog_erase(input logic [DATA_W-1:0] c);
    return is_legal(c) && c != BLANK_CHECK_CMD;
  endfunction

  fcsu_seq_t seq, next_seq;
  logic [DATA_W-1:0] flash_command, next_flash_command;
  logic [DATA_W-1:0] flash_clock_divider, next_flash_clock_divider;
  logic div_written, next_div_written;
  logic busy, next_busy;
  logic [DATA_W-1:0] cur_code, next_cur_code;
  logic pend, next_pend;
  logic [DATA_W-1:0] pend_code, next_pend_code;
  logic protect_violation_flag, next_protect_violation_flag;
  logic access_error_flag, next_access_error_flag;
  logic blank_verified_flag, next_blank_verified_flag;
  logic [1:0] sec, next_sec;
  logic stop_q, next_stop_q;
  fcsu_exec_t exec, next_exec;
  logic [IRQ_W-1:0] irq_stat, next_irq_stat;
  logic [IRQ_W-1:0] irq_mask, next_irq_mask;
  logic [DATA_W-1:0] rdata, next_rdata;
  logic irq, next_irq;

  logic cmd_buffer_empty_flag;
  logic cmd_complete_flag;
  logic wr_status, launch, launch_ok, stop_abort, prev_complete;
  logic [DATA_W-1:0] flash_status;

  // buffer is free when nothing waits and any running job is a burst
  assign cmd_buffer_empty_flag = !pend &&
                                 (!busy || cur_code == BURST_PROGRAM_CMD);
  assign cmd_complete_flag = !busy && !pend;
  assign wr_status = bus_in.wr && bus_in.addr == OFS_STATUS;
  // a one written while the buffer is full is simply ignored
  assign launch = wr_status && bus_in.wdata[ST_BUF_EMPTY] &&
                  cmd_buffer_empty_flag;
  assign stop_abort = stop_mode_in && !stop_q && busy;

  // status image; unused positions are hard zero
  always_comb begin
    flash_status = ZERO_BYTE;
    flash_status[ST_BUF_EMPTY] = cmd_buffer_empty_flag;
    flash_status[ST_COMPLETE] = cmd_complete_flag;
    flash_status[ST_PROT_VIOL] = protect_violation_flag;
    flash_status[ST_ACC_ERR] = access_error_flag;
    flash_status[ST_BLANK] = blank_verified_flag;
  end

  // sequence checking, launch and flag updates
  always_comb begin
    next_seq = seq;
    next_flash_command = flash_command;
    next_flash_clock_divider = flash_clock_divider;
    next_div_written = div_written;
    next_busy = busy;
    next_cur_code = cur_code;
    next_pend = pend;
    next_pend_code = pend_code;
    next_protect_violation_flag = protect_violation_flag;
    next_access_error_flag = access_error_flag;
    next_blank_verified_flag = blank_verified_flag;
    next_sec = sec;
    next_stop_q = stop_mode_in;
    next_exec = '{start: 1'b0, code: exec.code};
    launch_ok = 1'b0;
    // software clears happen first so a same-cycle set wins
    if (wr_status && bus_in.wdata[ST_PROT_VIOL]) begin
      next_protect_violation_flag = 1'b0;
    end
    if (wr_status && bus_in.wdata[ST_ACC_ERR]) begin
      next_access_error_flag = 1'b0;
    end
    if (bus_in.wr && bus_in.addr == OFS_DIVIDER) begin
      next_flash_clock_divider = bus_in.wdata;
      next_div_written = 1'b1;
    end
    // software order: array write, command write, launch
    if (array_wr_in) begin
      if (seq == SEQ_IDLE) begin
        next_seq = SEQ_DATA;
      end else begin
        next_seq = SEQ_IDLE;
        next_access_error_flag = 1'b1;
      end
    end
    if (bus_in.wr && bus_in.addr == OFS_COMMAND) begin
      next_flash_command = bus_in.wdata;
      if (seq == SEQ_DATA) begin
        next_seq = SEQ_CMD;
      end else begin
        next_seq = SEQ_IDLE;
        next_access_error_flag = 1'b1;
      end
    end
    if (launch) begin
      next_seq = SEQ_IDLE;
      if (seq != SEQ_CMD || !is_legal(flash_command)) begin
        next_access_error_flag = 1'b1;
      end else if (is_prog_erase(flash_command) && !div_written) begin
        next_access_error_flag = 1'b1;
      end else if (is_prog_erase(flash_command) && target_protected_in) begin
        next_protect_violation_flag = 1'b1;
      end else if (busy && flash_command != BURST_PROGRAM_CMD) begin
        next_access_error_flag = 1'b1;
      end else begin
        launch_ok = 1'b1;
        next_blank_verified_flag = 1'b0;
        if (busy) begin
          next_pend = 1'b1;
          next_pend_code = flash_command;
        end else begin
          next_busy = 1'b1;
          next_cur_code = flash_command;
          next_exec = '{start: 1'b1, code: flash_command};
        end
      end
    end
    // engine finished: hand over the buffered burst or go idle
    if (busy && exec_done_in) begin
      if (cur_code == BLANK_CHECK_CMD && blank_ok_in) begin
        next_blank_verified_flag = 1'b1;
        next_sec = SEC_UNSECURED;
      end
      // a burst buffered in this very cycle is handed over too, else it
      // would sit in the buffer with the engine idle and never start
      if (next_pend) begin
        next_pend = 1'b0;
        next_cur_code = next_pend_code;
        next_exec = '{start: 1'b1, code: next_pend_code};
      end else begin
        next_busy = 1'b0;
      end
    end
    // stop entry kills the running and buffered job
    if (stop_abort) begin
      next_access_error_flag = 1'b1;
      next_busy = 1'b0;
      next_pend = 1'b0;
      next_exec.start = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      seq <= SEQ_IDLE;
      flash_command <= COMMAND_RST;
      flash_clock_divider <= DIVIDER_RST;
      div_written <= 1'b0;
      busy <= 1'b0;
      cur_code <= COMMAND_RST;
      pend <= 1'b0;
      pend_code <= COMMAND_RST;
      protect_violation_flag <= 1'b0;
      access_error_flag <= 1'b0;
      blank_verified_flag <= 1'b0;
      sec <= SEC_SECURED;
      stop_q <= 1'b0;
      exec <= '0;
    end else begin
      seq <= next_seq;
      flash_command <= next_flash_command;
      flash_clock_divider <= next_flash_clock_divider;
      div_written <= next_div_written;
      busy <= next_busy;
      cur_code <= next_cur_code;
      pend <= next_pend;
      pend_code <= next_pend_code;
      protect_violation_flag <= next_protect_violation_flag;
      access_error_flag <= next_access_error_flag;
      blank_verified_flag <= next_blank_verified_flag;
      sec <= next_sec;
      stop_q <= next_stop_q;
      exec <= next_exec;
    end
  end

  // read port and sticky interrupt bits; a read clears, but a new event
  // in the same cycle survives it
  logic [IRQ_W-1:0] irq_event;
  always_comb begin
    irq_event = '0;
    irq_event[IQ_DONE] = cmd_complete_flag && !prev_complete;
    irq_event[IQ_PROT] = next_protect_violation_flag &&
                         !protect_violation_flag;
    irq_event[IQ_ACCERR] = next_access_error_flag && !access_error_flag;
    irq_event[IQ_BLANK] = next_blank_verified_flag && !blank_verified_flag;
    next_irq_stat = irq_stat;
    next_irq_mask = irq_mask;
    next_rdata = ZERO_BYTE;
    if (bus_in.rd) begin
      case (bus_in.addr)
        OFS_STATUS: next_rdata = flash_status;
        OFS_COMMAND: next_rdata = flash_command;
        OFS_DIVIDER: next_rdata = flash_clock_divider;
        OFS_IRQ_STATUS: begin
          next_rdata = {{(DATA_W-IRQ_W){1'b0}}, irq_stat};
          next_irq_stat = '0;
        end
        OFS_IRQ_MASK: next_rdata = {{(DATA_W-IRQ_W){1'b0}}, irq_mask};
        default: next_rdata = ZERO_BYTE;
      endcase
    end
    if (bus_in.wr && bus_in.addr == OFS_IRQ_MASK) begin
      next_irq_mask = bus_in.wdata[IRQ_W-1:0];
    end
    next_irq_stat = next_irq_stat | irq_event;
    next_irq = |(next_irq_stat & next_irq_mask);
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_stat <= IRQ_RST;
      irq_mask <= IRQ_RST;
      rdata <= ZERO_BYTE;
      irq <= 1'b0;
      prev_complete <= 1'b1;
    end else begin
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      rdata <= next_rdata;
      irq <= next_irq;
      prev_complete <= cmd_complete_flag;
    end
  end

  assign rdata_out = rdata;
  assign irq_out = irq;
  assign exec_out = exec;
  assign security_state_field_out = sec;
  assign unused_out = '0;

  // checks
  property p_rsvd_zero;
    @(posedge sys_clk_in) disable iff (rst_in)
    bus_in.rd && bus_in.addr == OFS_STATUS |=>
      rdata_out[3] == 1'b0 && rdata_out[1] == 1'b0 && rdata_out[0] == 1'b0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved status bit read as one");

  property p_launch_start;
    @(posedge sys_clk_in) disable iff (rst_in)
    launch_ok && !busy && !stop_abort |=>
      exec_out.start && exec_out.code == $past(flash_command) ##1
      !exec_out.start;
  endproperty
  a_launch_start: assert property (p_launch_start)
    else $error("valid launch did not start engine for one cycle");

  property p_complete_clears;
    @(posedge sys_clk_in) disable iff (rst_in)
    launch_ok && !stop_abort |=> !cmd_complete_flag;
  endproperty
  a_complete_clears: assert property (p_complete_clears)
    else $error("complete flag still set after launch");

  property p_protect;
    @(posedge sys_clk_in) disable iff (rst_in)
    launch && seq == SEQ_CMD && is_prog_erase(flash_command) &&
      div_written && target_protected_in |=>
      protect_violation_flag && !exec_out.start;
  endproperty
  a_protect: assert property (p_protect)
    else $error("protected target not flagged or not dropped");

  property p_illegal;
    @(posedge sys_clk_in) disable iff (rst_in)
    launch && !is_legal(flash_command) |=>
      access_error_flag && !exec_out.start;
  endproperty
  a_illegal: assert property (p_illegal)
    else $error("illegal code did not raise access error");

  property p_no_divider;
    @(posedge sys_clk_in) disable iff (rst_in)
    launch && seq == SEQ_CMD && is_prog_erase(flash_command) &&
      !div_written |=> access_error_flag && !exec_out.start;
  endproperty
  a_no_divider: assert property (p_no_divider)
    else $error("program before divider write not flagged");

  property p_stop;
    @(posedge sys_clk_in) disable iff (rst_in)
    stop_mode_in && !stop_q && busy |=> access_error_flag && !busy;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop during command not flagged");

  property p_accerr_hold;
    @(posedge sys_clk_in) disable iff (rst_in)
    access_error_flag && !(wr_status && bus_in.wdata[ST_ACC_ERR]) |=>
      access_error_flag;
  endproperty
  a_accerr_hold: assert property (p_accerr_hold)
    else $error("access error cleared without a one written");

  property p_blank_set;
    @(posedge sys_clk_in) disable iff (rst_in)
    busy && exec_done_in && cur_code == BLANK_CHECK_CMD && blank_ok_in |=>
      blank_verified_flag && security_state_field_out == SEC_UNSECURED;
  endproperty
  a_blank_set: assert property (p_blank_set)
    else $error("passed blank check not recorded");

  property p_blank_write;
    @(posedge sys_clk_in) disable iff (rst_in)
    wr_status && !launch_ok && !exec_done_in |=> $stable(blank_verified_flag);
  endproperty
  a_blank_write: assert property (p_blank_write)
    else $error("blank flag changed by direct write");

  c_burst_buffered: cover property (@(posedge sys_clk_in)
    disable iff (rst_in) pend && exec_done_in);
  c_blank_pass: cover property (@(posedge sys_clk_in)
    disable iff (rst_in) blank_verified_flag && cmd_complete_flag);
  c_irq: cover property (@(posedge sys_clk_in)
    disable iff (rst_in) irq_out);
endmodule

// file: tb/tb_top.sv
// tb_top: self-checking bench for the flash command/status unit.
// assumes fcsu_top keeps its own assertions; the bench plays software,
// the array engine and the stop indication from the same 250 MHz clock.
`timescale 1ns/1ps
module tb_top;
  import fcsu_pkg::*;
  // clock, reset and design-facing signals
  logic sys_clk_in;
  logic rst_in;
  fcsu_bus_req_t bus;
  logic [DATA_W-1:0] rdata;
  logic array_wr;
  logic prot;
  logic stop;
  logic done;
  logic blank_ok;
  fcsu_exec_t exec;
  logic [1:0] sec;
  logic irq;
  logic [DATA_W-1:0] tmp;
  int failures;
  int n_tests;

  fcsu_top i_fcsu_top (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .bus_in(bus),
    .unused_out(),
    .rdata_out(rdata),
    .array_wr_in(array_wr),
    .target_protected_in(prot),
    .stop_mode_in(stop),
    .exec_out(exec),
    .exec_done_in(done),
    .blank_ok_in(blank_ok),
    .security_state_field_out(sec),
    .irq_out(irq)
  );

  // free-running system clock, 4 ns period
  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe; a gap cycle keeps strobes from colliding
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge sys_clk_in);
    bus.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge sys_clk_in);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic chk_rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    rd(a, tmp);
    check(tmp, exp);
  endtask

  // array write, command write, then launch through the empty flag
  task automatic launch(input logic [7:0] code);
    @(posedge sys_clk_in);
    array_wr <= 1'b1;
    @(posedge sys_clk_in);
    array_wr <= 1'b0;
    wr(OFS_COMMAND, code);
    wr(OFS_STATUS, 8'h80);
    #1;
  endtask

  // started code, or zero when no start pulse stands now
  function automatic logic [7:0] started();
    return (exec.start === 1'b1) ? exec.code : 8'h00;
  endfunction

  task automatic finish_cmd(input logic b);
    @(posedge sys_clk_in);
    done <= 1'b1;
    blank_ok <= b;
    @(posedge sys_clk_in);
    done <= 1'b0;
    #1;
  endtask

  task automatic t_reset();
    chk_rd(OFS_STATUS, 8'hC0);
    check({6'h0, sec}, {6'h0, SEC_SECURED});
    chk_rd(3'h5, ZERO_BYTE);
    check({7'h0, irq}, 8'h00);
  endtask

  // program attempt before the divider is written, then flag clearing
  task automatic t_nodiv();
    launch(BYTE_PROGRAM_CMD);
    check(started(), 8'h00);
    chk_rd(OFS_STATUS, 8'hD0);
    wr(OFS_STATUS, 8'h0B);
    chk_rd(OFS_STATUS, 8'hD0);
    wr(OFS_STATUS, 8'h00);
    chk_rd(OFS_STATUS, 8'hD0);
    wr(OFS_STATUS, 8'h10);
    chk_rd(OFS_STATUS, 8'hC0);
  endtask

  task automatic t_codes();
    logic [7:0] codes [4];
    codes = '{BYTE_PROGRAM_CMD, BURST_PROGRAM_CMD, PAGE_ERASE_CMD,
              MASS_ERASE_CMD};
    wr(OFS_DIVIDER, 8'h13);
    foreach (codes[i]) begin
      launch(codes[i]);
      check(started(), codes[i]);
      // a lone running burst leaves the buffer free
      chk_rd(OFS_STATUS, (codes[i] == 8'h25) ? 8'h80 : 8'h00);
      finish_cmd(1'b0);
      chk_rd(OFS_STATUS, 8'hC0);
    end
  endtask

  // illegal code, out-of-order command write, protected erase
  task automatic t_errors();
    launch(8'h33);
    check(started(), 8'h00);
    chk_rd(OFS_STATUS, 8'hD0);
    wr(OFS_STATUS, 8'h10);
    wr(OFS_COMMAND, PAGE_ERASE_CMD);
    chk_rd(OFS_STATUS, 8'hD0);
    wr(OFS_STATUS, 8'h10);
    @(posedge sys_clk_in);
    prot <= 1'b1;
    launch(PAGE_ERASE_CMD);
    check(started(), 8'h00);
    chk_rd(OFS_STATUS, 8'hE0);
    @(posedge sys_clk_in);
    prot <= 1'b0;
    wr(OFS_STATUS, 8'h20);
    chk_rd(OFS_STATUS, 8'hC0);
  endtask

  task automatic t_blank();
    launch(BLANK_CHECK_CMD);
    check(started(), BLANK_CHECK_CMD);
    finish_cmd(1'b1);
    chk_rd(OFS_STATUS, 8'hC4);
    check({6'h0, sec}, {6'h0, SEC_UNSECURED});
    wr(OFS_STATUS, 8'h04);
    chk_rd(OFS_STATUS, 8'hC4);
    launch(BYTE_PROGRAM_CMD);
    chk_rd(OFS_STATUS, 8'h00);
    finish_cmd(1'b0);
  endtask

  // second burst waits in the buffer until the first completes
  task automatic t_burst();
    launch(BURST_PROGRAM_CMD);
    launch(BURST_PROGRAM_CMD);
    check(started(), 8'h00);
    chk_rd(OFS_STATUS, 8'h00);
    finish_cmd(1'b0);
    check(started(), BURST_PROGRAM_CMD);
    chk_rd(OFS_STATUS, 8'h80);
    finish_cmd(1'b0);
    chk_rd(OFS_STATUS, 8'hC0);
  endtask

  task automatic t_stop();
    launch(MASS_ERASE_CMD);
    @(posedge sys_clk_in);
    stop <= 1'b1;
    @(posedge sys_clk_in);
    stop <= 1'b0;
    chk_rd(OFS_STATUS, 8'hD0);
    wr(OFS_STATUS, 8'h30);
  endtask

  // access error raises the line only while its mask bit is set
  task automatic t_irq();
    rd(OFS_IRQ_STATUS, tmp);
    wr(OFS_IRQ_MASK, 8'h04);
    launch(8'hFF);
    // the line must be seen before the status read clears the sticky bit
    check({7'h0, irq}, 8'h01);
    chk_rd(OFS_IRQ_STATUS, 8'h04);
    repeat (2) @(posedge sys_clk_in);
    #1 check({7'h0, irq}, 8'h00);
    wr(OFS_STATUS, 8'h10);
    wr(OFS_IRQ_MASK, 8'h00);
    launch(8'h33);
    repeat (2) @(posedge sys_clk_in);
    #1 check({7'h0, irq}, 8'h00);
    chk_rd(OFS_IRQ_STATUS, 8'h04);
  endtask

  task automatic summarize();
    $display("comparisons=%0d mismatches=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // watchdog: the sequence needs well under 2000 cycles
  initial begin
    #(4 * 20000);
    failures++;
    summarize();
  end

  // main sequence
  initial begin
    failures = 0;
    n_tests = 0;
    bus = '0;
    array_wr = 1'b0;
    prot = 1'b0;
    stop = 1'b0;
    done = 1'b0;
    blank_ok = 1'b0;
    rst_in = 1'b1;
    repeat (3) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_nodiv();
    t_codes();
    t_errors();
    t_blank();
    t_burst();
    t_stop();
    t_irq();
    summarize();
  end
endmodule
